// ===== hdl/power_mode_controller.sv
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
// Operation
// - Four modes; reset enters Active
// - Active: main clock, oscillator on, watchdog slow
// - Power Save: modules run on slow clock
// - Power Save by wait stalls CPU
// - Idle: only mode and watchdog units, slow
// - Halt: all clocks off except the wake-up unit's, oscillator off
// - Halt: slow clock signal stops toggling
// - Low-frequency oscillator always runs
// - Oscillator off in Save/Idle only if present
// - Lower modes entered only by software write or wait
// - Maskable or non-maskable interrupt wakes
// - Wake-up unit clocked in every mode
// - Wake event latched until acknowledge or reset
// - Wake restores Active, execution waits service
// - Wait in Active stalls until interrupt
// - Power-save request immediate or at wait
// - Idle/Halt from Active needs wait-first bit
// - Wake clears high-frequency disable bit
// - Save/Idle entry needs stable slow clock; Idle entry from Power Save at a wait does not check it
module power_mode_controller
   import power_mode_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic wait_exec,
   input wire logic wake_maskable,
   input wire logic wake_nmi,
   input wire logic int_ack,
   input wire logic slow_stable_pin,
   input wire logic hf_stable_pin,
   input wire logic lf_present_pin,
   output clk_ctrl_t clk_ctrl,
   output mode_t power_mode
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [2:0] sync1_q; // First synchroniser stage, read only by stage two
   logic [2:0] sync2_q; // Synchronised oscillator status and strap
   logic slow_ok; // Slow clock running and stable
   logic hf_ok; // High-frequency clock stable
   logic lf_present; // Low-frequency crystal fitted
   logic ack_q; // Bus acknowledge
   logic [31:0] rdat_q; // Bus read data
   logic req; // Bus request standing
   logic wr; // Control register write commits this edge
   logic [7:0] wd; // Written byte
   logic save_req_q, hf_off_q, idle_q, halt_q, wbps_q; // Control bits
   logic wake_ev; // Wake event arriving this cycle
   logic wake_q; // Latched wake event
   logic stall_q; // CPU held after a wait
   mode_t mode_q, mode_d; // Operating mode
   route_t route_q, route_d; // Module clock source
   route_t route_tgt; // Source the mode asks for
   logic [1:0] gap_q, gap_d; // Dead-time counter
   clk_ctrl_t ctrl_q, ctrl_d; // Registered clock controls

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Status comes from oscillator circuits outside this clock domain
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
            end else begin
               sync1_q[gi] <= gi == 0 ? slow_stable_pin :
                              gi == 1 ? hf_stable_pin : lf_present_pin;
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate

   assign slow_ok = sync2_q[0];
   assign hf_ok = sync2_q[1];
   assign lf_present = sync2_q[2];

   // ----------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------
   assign req = wb_cyc_i & wb_stb_i;
   // A write takes effect on the edge where the master sees ack
   assign wr = req & wb_we_i & ack_q & wb_sel_i[0] & (wb_adr_i == PMCS_OFF);
   assign wd = wb_dat_i[7:0];
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // One wait state; ack drops the cycle after it is given
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // Read data captured with the ack; unmapped reads return zero
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdat_q <= 32'h0;
      end else if (req & ~ack_q) begin
         case (wb_adr_i)
            PMCS_OFF: begin
               rdat_q <= {24'h0, slow_ok, hf_ok, wbps_q, 1'b0,
                          halt_q, idle_q, hf_off_q, save_req_q};
            end
            MODE_OFF: begin
               rdat_q <= {28'h0, mode_q};
            end
            default: begin
               rdat_q <= 32'h0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Wake-up latch
   // ----------------------------------------------------------------
   assign wake_ev = wake_maskable | wake_nmi;

   // Set wins over acknowledge so a fresh event is never lost
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= wake_ev | (wake_q & ~int_ack);
      end
   end

   // CPU held after a wait until its interrupt is acknowledged
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         stall_q <= 1'b0;
      end else if (wait_exec) begin
         stall_q <= 1'b1;
      end else if (int_ack) begin
         stall_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Mode state machine
   // ----------------------------------------------------------------
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         MODE_ACTIVE: begin
            // Only a register write or a wait can leave Active
            if (wr && wd[SAVE_REQ_BIT] && !wd[WBPS_BIT] && slow_ok) begin
               mode_d = MODE_PSAVE;
            end else if (wait_exec && wbps_q) begin
               if (halt_q) begin
                  mode_d = MODE_HALT;
               end else if (idle_q && slow_ok) begin
                  mode_d = MODE_IDLE;
               end else if (save_req_q && slow_ok) begin
                  mode_d = MODE_PSAVE;
               end
            end
         end
         MODE_PSAVE: begin
            if (wake_q && hf_ok) begin
               mode_d = MODE_ACTIVE;
            end else if (wait_exec && halt_q) begin
               mode_d = MODE_HALT;
            end else if (wait_exec && idle_q) begin
               mode_d = MODE_IDLE;
            end else if (wr && !wd[SAVE_REQ_BIT] && hf_ok) begin
               mode_d = MODE_ACTIVE;
            end
         end
         MODE_IDLE, MODE_HALT: begin
            // Active needs a stable fast clock first
            if (wake_q && hf_ok) begin
               mode_d = MODE_ACTIVE;
            end
         end
         default: begin
            mode_d = MODE_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mode_q <= MODE_ACTIVE;
      end else begin
         mode_q <= mode_d;
      end
   end

   assign power_mode = mode_q;

   // ----------------------------------------------------------------
   // Control bits
   // ----------------------------------------------------------------
   // Request bit: set at entry, or at write when waiting for a wait
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         save_req_q <= PMCS_RESET[SAVE_REQ_BIT];
      end else if (wake_ev) begin
         save_req_q <= 1'b0;
      end else if (mode_d == MODE_PSAVE && mode_q != MODE_PSAVE) begin
         save_req_q <= 1'b1;
      end else if (mode_q == MODE_PSAVE && mode_d == MODE_ACTIVE) begin
         save_req_q <= 1'b0;
      end else if (wr && mode_q == MODE_ACTIVE) begin
         save_req_q <= wd[SAVE_REQ_BIT] & wd[WBPS_BIT];
      end
   end

   // Software bits, cleared by hardware on a wake event
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         hf_off_q <= PMCS_RESET[HF_OFF_BIT];
         idle_q <= PMCS_RESET[IDLE_BIT];
         halt_q <= PMCS_RESET[HALT_BIT];
      end else if (wake_ev) begin
         hf_off_q <= 1'b0;
         idle_q <= 1'b0;
         halt_q <= 1'b0;
      end else if (wr) begin
         hf_off_q <= wd[HF_OFF_BIT];
         idle_q <= wd[IDLE_BIT];
         halt_q <= wd[HALT_BIT];
      end
   end

   // Wait-first bit, software only
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wbps_q <= PMCS_RESET[WBPS_BIT];
      end else if (wr) begin
         wbps_q <= wd[WBPS_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Module clock routing
   // ----------------------------------------------------------------
   always_comb begin
      case (mode_q)
         MODE_ACTIVE: route_tgt = ROUTE_MAIN;
         MODE_PSAVE: route_tgt = ROUTE_SLOW;
         default: route_tgt = ROUTE_OFF;
      endcase
   end

   // Break before make: both enables stay low for the gap so the
   // gating cells never see two sources or a shortened pulse
   always_comb begin
      route_d = route_q;
      gap_d = gap_q;
      case (route_q)
         ROUTE_MAIN, ROUTE_SLOW: begin
            if (route_tgt != route_q) begin
               route_d = ROUTE_OFF;
               gap_d = GAP_CYC;
            end
         end
         ROUTE_OFF: begin
            if (gap_q != GAP_RESET) begin
               gap_d = gap_q - 2'h1;
            end else if (route_tgt != ROUTE_OFF) begin
               route_d = route_tgt;
            end
         end
         default: begin
            route_d = ROUTE_OFF;
            gap_d = GAP_CYC;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         route_q <= ROUTE_MAIN;
         gap_q <= GAP_RESET;
      end else begin
         route_q <= route_d;
         gap_q <= gap_d;
      end
   end

   // ----------------------------------------------------------------
   // Clock and oscillator controls
   // ----------------------------------------------------------------
   always_comb begin
      ctrl_d.main_en = route_q == ROUTE_MAIN;
      ctrl_d.slow_en = route_q == ROUTE_SLOW;
      ctrl_d.wdog_en = mode_q != MODE_HALT;
      ctrl_d.slow_run = mode_q != MODE_HALT;
      ctrl_d.lf_osc_en = 1'b1;
      ctrl_d.wake_clk_en = 1'b1;
      ctrl_d.cpu_stall = stall_q;
      // Oscillator restarts in Halt as soon as a wake is pending
      case (mode_q)
         MODE_ACTIVE: ctrl_d.hf_osc_en = 1'b1;
         MODE_HALT: ctrl_d.hf_osc_en = wake_q;
         default: ctrl_d.hf_osc_en = ~(hf_off_q & lf_present);
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl_q <= CLK_CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   assign clk_ctrl = ctrl_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   property p_active_hf;
      mode_q == MODE_ACTIVE |=> clk_ctrl.hf_osc_en && clk_ctrl.wdog_en;
   endproperty
   a_active_hf: assert property (p_active_hf)
      else $error("oscillator or watchdog clock off in Active");

   property p_halt_clocks;
      (mode_q == MODE_HALT) [*3] |-> !clk_ctrl.main_en && !clk_ctrl.slow_en;
   endproperty
   a_halt_clocks: assert property (p_halt_clocks)
      else $error("module clock running in Halt");

   property p_halt_slow;
      mode_q == MODE_HALT && !wake_q |=> !clk_ctrl.slow_run && !clk_ctrl.hf_osc_en;
   endproperty
   a_halt_slow: assert property (p_halt_slow)
      else $error("slow clock or oscillator alive in Halt");

   property p_sw_entry;
      mode_q == MODE_ACTIVE && !wr && !wait_exec |=> mode_q == MODE_ACTIVE;
   endproperty
   a_sw_entry: assert property (p_sw_entry)
      else $error("left Active without write or wait");

   property p_wake;
      wake_q && hf_ok && mode_q != MODE_ACTIVE |=> mode_q == MODE_ACTIVE;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake did not return to Active");

   property p_latch;
      wake_q && !int_ack |=> wake_q;
   endproperty
   a_latch: assert property (p_latch)
      else $error("wake latch lost before acknowledge");

   property p_stall;
      wait_exec |-> ##2 clk_ctrl.cpu_stall;
   endproperty
   a_stall: assert property (p_stall)
      else $error("CPU not stalled after wait");

   property p_wbps;
      mode_q == MODE_ACTIVE ##1 mode_q == MODE_IDLE |-> $past(wbps_q);
   endproperty
   a_wbps: assert property (p_wbps)
      else $error("Idle entered without wait-first bit");

   property p_bits_clear;
      wake_ev |=> !hf_off_q && !save_req_q && !idle_q && !halt_q;
   endproperty
   a_bits_clear: assert property (p_bits_clear)
      else $error("wake did not clear control bits");

   property p_slow_ok;
      mode_q == MODE_ACTIVE ##1 mode_q == MODE_PSAVE |-> $past(slow_ok);
   endproperty
   a_slow_ok: assert property (p_slow_ok)
      else $error("Power Save entered with unstable slow clock");

   property p_gap;
      $fell(clk_ctrl.main_en) |-> !clk_ctrl.slow_en [*2];
   endproperty
   a_gap: assert property (p_gap)
      else $error("clock sources overlap");

   // Both gating cells open at once would merge two clocks into runts
   property p_one_src;
      !(clk_ctrl.main_en && clk_ctrl.slow_en);
   endproperty
   a_one_src: assert property (p_one_src)
      else $error("main and slow module clocks enabled together");

   // Without a slow crystal the fast oscillator is the only source left
   property p_hf_keep;
      (mode_q == MODE_PSAVE || mode_q == MODE_IDLE) && !lf_present |=> clk_ctrl.hf_osc_en;
   endproperty
   a_hf_keep: assert property (p_hf_keep)
      else $error("oscillator stopped with no slow crystal fitted");

   c_psave: cover property (mode_q == MODE_ACTIVE ##1 mode_q == MODE_PSAVE);
   c_halt: cover property (mode_q == MODE_HALT ##[1:50] mode_q == MODE_ACTIVE);
   c_idle: cover property (mode_q == MODE_IDLE ##[1:50] mode_q == MODE_ACTIVE);

endmodule

// ===== include/power_mode_pkg.sv
// ----------------------------------------------------------------
// Power mode controller constants and types
// ----------------------------------------------------------------
package power_mode_pkg;

   // Register byte offsets on the bus
   localparam logic [3:0] PMCS_OFF = 4'h0;
   localparam logic [3:0] MODE_OFF = 4'h4;

   // Control/status field positions
   localparam int SAVE_REQ_BIT = 0;
   localparam int HF_OFF_BIT = 1;
   localparam int IDLE_BIT = 2;
   localparam int HALT_BIT = 3;
   localparam int WBPS_BIT = 5;
   localparam int HFOK_BIT = 6;
   localparam int LFOK_BIT = 7;

   // Values after reset
   localparam logic [7:0] PMCS_RESET = 8'h00;
   localparam logic [1:0] GAP_RESET = 2'h0;

   // Dead-time counter load when the clock source changes; no module clock for three cycles
   localparam logic [1:0] GAP_CYC = 2'h2;

   // Operating modes
   typedef enum logic [3:0] {
      MODE_ACTIVE = 4'b0001,
      MODE_PSAVE = 4'b0010,
      MODE_IDLE = 4'b0100,
      MODE_HALT = 4'b1000
   } mode_t;

   // Source of the module clock
   typedef enum logic [2:0] {
      ROUTE_MAIN = 3'b001,
      ROUTE_SLOW = 3'b010,
      ROUTE_OFF = 3'b100
   } route_t;

   // Clock and oscillator controls leaving the block
   typedef struct packed {
      logic main_en;
      logic slow_en;
      logic wdog_en;
      logic slow_run;
      logic hf_osc_en;
      logic lf_osc_en;
      logic wake_clk_en;
      logic cpu_stall;
   } clk_ctrl_t;

   // Active routing out of reset: main clock only, oscillators on, CPU free
   localparam clk_ctrl_t CLK_CTRL_RESET = 8'hbe;

endpackage

// ===== tb/osc_wake_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Far side: slow and fast oscillators with start-up delays
// ------------------------------------------------------------
module osc_wake_model
   import power_mode_pkg::*;
#(
   parameter int SLOW_START = 24,
   parameter int HF_START = 6
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input clk_ctrl_t clk_ctrl,
   input wire logic lf_fit,
   output logic slow_stable_pin,
   output logic hf_stable_pin,
   output logic lf_present_pin
);
   logic [7:0] slow_cnt_q; // Cycles since reset, saturating
   logic [7:0] hf_cnt_q; // Cycles the fast oscillator has been enabled

   // Slow oscillator settles once after reset, then never stops
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         slow_cnt_q <= 8'h00;
      end else if (slow_cnt_q < 8'(SLOW_START)) begin
         slow_cnt_q <= slow_cnt_q + 8'h01;
      end
   end

   // Fast oscillator is unstable for a while after enable, gone at once when off
   always_ff @(posedge core_clk) begin
      if (!rst_n || !clk_ctrl.hf_osc_en) begin
         hf_cnt_q <= 8'h00;
      end else if (hf_cnt_q < 8'(HF_START)) begin
         hf_cnt_q <= hf_cnt_q + 8'h01;
      end
   end

   assign slow_stable_pin = (slow_cnt_q >= 8'(SLOW_START));
   assign hf_stable_pin = (hf_cnt_q >= 8'(HF_START));
   // Crystal strap set by the bench, so both package options get exercised
   assign lf_present_pin = lf_fit;
endmodule

// ===== tb/power_mode_controller_test.sv
`timescale 1ns/1ps
module power_mode_controller_test;
   import power_mode_pkg::*;
   // Row: value written, wait pulse, expected mode, expected clock fields
   typedef struct packed {
      logic [7:0] wdat;
      logic wt;
      mode_t mode;
      logic [6:0] ctrl;
   } row_t;
   localparam row_t ROWS [6] = '{
      '{8'h01, 1'b0, MODE_PSAVE, 7'h3f},
      '{8'h21, 1'b1, MODE_PSAVE, 7'h3f},
      '{8'h23, 1'b1, MODE_PSAVE, 7'h3b},
      '{8'h24, 1'b1, MODE_IDLE, 7'h1f},
      '{8'h28, 1'b1, MODE_HALT, 7'h03},
      '{8'h08, 1'b1, MODE_ACTIVE, 7'h5f}
   };
   logic core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic wb_ack_o, wait_exec, wake_maskable, wake_nmi, int_ack;
   logic slow_stable_pin, hf_stable_pin, lf_present_pin, lf_fit;
   clk_ctrl_t clk_ctrl;
   mode_t power_mode;
   int err_count, checked, cycles;

   power_mode_controller DUT (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .wait_exec(wait_exec), .wake_maskable(wake_maskable), .wake_nmi(wake_nmi),
      .int_ack(int_ack), .slow_stable_pin(slow_stable_pin),
      .hf_stable_pin(hf_stable_pin), .lf_present_pin(lf_present_pin),
      .clk_ctrl(clk_ctrl), .power_mode(power_mode));
   osc_wake_model partner (.core_clk(core_clk), .rst_n(rst_n), .clk_ctrl(clk_ctrl),
      .lf_fit(lf_fit), .slow_stable_pin(slow_stable_pin), .hf_stable_pin(hf_stable_pin),
      .lf_present_pin(lf_present_pin));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Classic single cycle; holds the request until ack is sampled high
   // No cycle count is assumed: only the bench timeout ends a hang
   task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h000000, d};
      do begin
         @(posedge core_clk);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge core_clk);
   endtask

   // One-cycle strobe: 0 wait, 1 maskable wake, 2 non-maskable wake, 3 acknowledge
   task automatic strobe(input int k);
      case (k)
         0: wait_exec <= 1'b1;
         1: wake_maskable <= 1'b1;
         2: wake_nmi <= 1'b1;
         default: int_ack <= 1'b1;
      endcase
      @(posedge core_clk);
      {wait_exec, wake_maskable, wake_nmi, int_ack} <= 4'h0;
      @(posedge core_clk);
   endtask

   // Bounded wait for a mode; the clock switch gap then gets time to settle
   task automatic wait_mode(input mode_t m);
      for (int n = 0; n < 60 && power_mode !== m; n++) begin
         @(posedge core_clk);
      end
      repeat (6) @(posedge core_clk);
   endtask

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // Cuts a hang short
   always @(posedge core_clk) begin
      cycles++;
      if (cycles > 20000) begin
         err_count++;
         conclude();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      err_count = 0;
      checked = 0;
      cycles = 0;
      rst_n = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wait_exec, wake_maskable, wake_nmi, int_ack} = 7'h00;
      wb_adr_i = 4'h0;
      wb_sel_i = 4'h1;
      lf_fit = 1'b1;
      wb_dat_i = 32'h0;
      repeat (4) @(posedge core_clk);
      chk(power_mode, MODE_ACTIVE);
      rst_n <= 1'b1;
      repeat (40) @(posedge core_clk);
      foreach (ROWS[i]) begin
         wb(1'b1, PMCS_OFF, ROWS[i].wdat);
         if (ROWS[i].wt) strobe(0);
         wait_mode(ROWS[i].mode);
         chk(power_mode, ROWS[i].mode);
         chk(clk_ctrl[7:1], ROWS[i].ctrl);
         chk(clk_ctrl.cpu_stall, ROWS[i].wt);
         wb(1'b0, MODE_OFF, 8'h00);
         chk(rd, {28'h0, ROWS[i].mode});
         strobe(1 + (i % 2));
         wait_mode(MODE_ACTIVE);
         chk(power_mode, MODE_ACTIVE);
         chk(clk_ctrl[7:1], 7'h5f);
         chk(clk_ctrl.cpu_stall, ROWS[i].wt);
         wb(1'b0, PMCS_OFF, 8'h00);
         chk(rd[3:0], 4'h0);
         strobe(3);
         repeat (3) @(posedge core_clk);
         chk(clk_ctrl.cpu_stall, 1'b0);
      end
      // Software return from power save
      wb(1'b1, PMCS_OFF, 8'h01);
      wait_mode(MODE_PSAVE);
      wb(1'b1, PMCS_OFF, 8'h00);
      wait_mode(MODE_ACTIVE);
      chk(power_mode, MODE_ACTIVE);
      // Unmapped place reads zero and ignores writes
      wb(1'b1, 4'hc, 8'hff);
      wb(1'b0, 4'hc, 8'h00);
      chk(rd, 32'h0);
      chk(power_mode, MODE_ACTIVE);
      // Second reset mid-run; slow clock not yet stable refuses power save
      rst_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk(power_mode, MODE_ACTIVE);
      rst_n <= 1'b1;
      @(posedge core_clk);
      wb(1'b0, PMCS_OFF, 8'h00);
      chk(rd[7:0], PMCS_RESET);
      wb(1'b1, PMCS_OFF, 8'h01);
      repeat (4) @(posedge core_clk);
      chk(power_mode, MODE_ACTIVE);
      wb(1'b0, PMCS_OFF, 8'h00);
      chk(rd[0], 1'b0);
      repeat (30) @(posedge core_clk);
      wb(1'b0, PMCS_OFF, 8'h00);
      chk(rd[7], 1'b1);
      // Write with byte lane 0 disabled must leave the register alone
      wb_sel_i <= 4'h0;
      wb(1'b1, PMCS_OFF, 8'h20);
      wb_sel_i <= 4'h1;
      wb(1'b0, PMCS_OFF, 8'h00);
      chk(rd[5], 1'b0);
      // No slow crystal: the fast oscillator must keep running in Power Save
      lf_fit <= 1'b0;
      repeat (4) @(posedge core_clk);
      wb(1'b1, PMCS_OFF, 8'h03);
      wait_mode(MODE_PSAVE);
      chk(power_mode, MODE_PSAVE);
      chk(clk_ctrl.hf_osc_en, 1'b1);
      wb(1'b1, PMCS_OFF, 8'h00);
      wait_mode(MODE_ACTIVE);
      chk(power_mode, MODE_ACTIVE);
      conclude();
   end
endmodule
